// >>> design/dspfc_channel.sv
module dspfc_channel
  import dspfc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Timing from the counter
  input wire logic tick,
  input wire logic load,
  input wire logic up_slope,
  input wire logic [CNT_W-1:0] count,
  // Configuration
  input wire logic [CNT_W-1:0] buffer,
  input wire logic [1:0] out_mode,
  input wire logic toggle_ok,
  // Results
  output logic [CNT_W-1:0] active,
  output logic match,
  output logic level
);

  logic [CNT_W-1:0] active_q;
  logic level_q;

  assign active = active_q;
  assign level = level_q;

  // Full-width compare; a value above TOP is never reached
  assign match = tick && (count == active_q);

  // Active compare copied from the buffer only when the counter allows
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      active_q <= CNT_RESET;
    end
    else if (load)
    begin
      active_q <= buffer;
    end
  end

  // Output level: clear/set by slope, or toggle
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      level_q <= 1'b0;
    end
    else if (match)
    begin
      case (out_mode)
        OUT_NONINV: level_q <= !up_slope;
        OUT_INV: level_q <= up_slope;
        OUT_TOGGLE: level_q <= toggle_ok ? !level_q : level_q;
        default: level_q <= level_q;
      endcase
    end
  end

  a_active_hold: assert property (@(posedge clock) disable iff (reset)
    !load |=> $stable(active_q)) else $error("active compare changed without load");
  a_noninv_edge: assert property (@(posedge clock) disable iff (reset)
    match && out_mode == OUT_NONINV |=> level_q == !$past(up_slope))
    else $error("non-inverted level wrong after match");
  a_toggle_flip: assert property (@(posedge clock) disable iff (reset)
    match && out_mode == OUT_TOGGLE && toggle_ok |=> level_q != $past(level_q))
    else $error("toggle output did not flip");

endmodule

// >>> design/dspfc_pkg.sv
package dspfc_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int CTRL_W = 15;
  localparam int FLAG_W = 4;
  localparam int PRE_W = 10;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_A = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_B = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h14;

  // ****************************************
  // Control field positions and reset values
  // ****************************************
  localparam int CTL_WAVE_LSB = 0;
  localparam int CTL_OUT_LSB = 4;
  localparam int CTL_CLKSEL_LSB = 8;
  localparam int CTL_DIR_LSB = 11;
  localparam int CTL_PORT_LSB = 13;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_BOTTOM = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // ****************************************
  // Flag positions
  // ****************************************
  localparam int FLG_OVERFLOW = 0;
  localparam int FLG_MATCH_A = 1;
  localparam int FLG_CAPTURE = 3;
  localparam int STS_UP_POS = 8;

  // ****************************************
  // Mode encodings
  // ****************************************
  localparam logic [3:0] WAVE_TOP_CAPTURE = 4'h8;
  localparam logic [3:0] WAVE_TOP_COMPARE = 4'h9;
  localparam logic [3:0] WAVE_PC_COMPARE = 4'hB;
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_NONINV = 2'h2;
  localparam logic [1:0] OUT_INV = 2'h3;

  // ****************************************
  // Prescaler selections and divisor masks
  // ****************************************
  localparam logic [2:0] CLK_DIV1 = 3'h1;
  localparam logic [2:0] CLK_DIV8 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h3;
  localparam logic [2:0] CLK_DIV256 = 3'h4;
  localparam logic [2:0] CLK_DIV1024 = 3'h5;
  localparam logic [PRE_W-1:0] MASK_DIV8 = 10'h007;
  localparam logic [PRE_W-1:0] MASK_DIV64 = 10'h03F;
  localparam logic [PRE_W-1:0] MASK_DIV256 = 10'h0FF;
  localparam logic [PRE_W-1:0] MASK_DIV1024 = 10'h3FF;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> design/dspfc_prescaler.sv
module dspfc_prescaler
  import dspfc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Selection and tick
  input wire logic [2:0] clk_sel,
  output logic tick
);

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] mask;
  logic enabled;

  // Free-running divider
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pre_q <= '0;
    end
    else
    begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // Divisor mask for 1, 8, 64, 256 or 1024; other selections stop the timer
  always_comb
  begin
    mask = '0;
    enabled = 1'b1;
    case (clk_sel)
      CLK_DIV1: mask = '0;
      CLK_DIV8: mask = MASK_DIV8;
      CLK_DIV64: mask = MASK_DIV64;
      CLK_DIV256: mask = MASK_DIV256;
      CLK_DIV1024: mask = MASK_DIV1024;
      default: enabled = 1'b0;
    endcase
  end

  // One clock-wide enable per prescaled period
  assign tick = enabled && ((pre_q & mask) == mask);

endmodule

// >>> design/dspfc_timer.sv
// Overview of operation
// - Counter runs zero up to TOP, then back down to zero, repeatedly.
// - Waveform mode 8 takes TOP from capture, mode 9 from compare A.
// - Counter holds TOP for exactly one tick, then counts down.
// - Non-inverting clears on up-count match, sets on down-count match; inverting opposite.
// - Output mode 2 gives non-inverted PWM, 3 gives inverted PWM.
// - Active compares load from buffers at BOTTOM, in mode 11 at TOP; overflow flag set at BOTTOM.
// - At TOP, set compare A flag or capture flag, whichever defines TOP.
// - Each channel sets its match flag when counter equals its active compare.
// - Waveform reaches the pin only when its direction bit selects output.
// - Compare at BOTTOM holds output low, at TOP high; inverted opposite.
// - Mode 9 with output A mode 1 toggles A on each match.
// - Mode 11 with output A mode 1 also toggles A, 50% duty.
// - Tick is clock divided by 1, 8, 64, 256 or 1024.
// - Everything runs on the clock; the tick only enables updates.
// - Output mode 0 disconnects the waveform, pin under port control.
// - With capture as TOP, the capture input pin is ignored.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
module dspfc_timer
  import dspfc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dspfc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [dspfc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [dspfc_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [dspfc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Capture input
  input wire logic capture_input_pin,
  // Waveform pins A and B
  output logic [1:0] wave_pin_out,
  output logic [1:0] wave_pin_oe
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0] counter_value_q;
  logic up_q;
  logic [CNT_W-1:0] compare_buf_q [2];
  logic [CNT_W-1:0] capture_register_q;
  logic [FLAG_W-1:0] flags_q;
  logic capture_prev_q;
  logic pin_out_q [2];
  logic pin_oe_q [2];
  logic [3:0] waveform_mode_field;
  logic [2:0] clk_sel;
  logic timer_tick;
  logic running;
  logic toggle_a;
  logic step;
  logic [CNT_W-1:0] top;
  logic at_top;
  logic at_bottom;
  logic up_slope;
  logic load;
  logic [1:0] match;
  logic [1:0] level;
  logic [CNT_W-1:0] active [2];
  logic capture_event;
  // Bus state
  logic aw_full_q;
  logic w_full_q;
  logic aw_full_d;
  logic w_full_d;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wbits;
  logic wr_ctrl;
  logic wr_cap;
  logic wr_flags;
  logic [1:0] wr_cmp;
  logic ar_hs;
  logic rvalid_d;

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wave_pin_out = {pin_out_q[1], pin_out_q[0]};
  assign wave_pin_oe = {pin_oe_q[1], pin_oe_q[0]};

  // ****************************************
  // Bus write path
  // ****************************************

  // Address and data are latched in either order; the write runs once both are held
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign aw_full_d = !do_write && (aw_full_q || (s_axi_awvalid && awready_q));
  assign w_full_d = !do_write && (w_full_q || (s_axi_wvalid && wready_q));
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wbits = wdata_q & wmask;
  assign wr_ctrl = do_write && (waddr_q == OFS_CONTROL);
  assign wr_cmp[0] = do_write && (waddr_q == OFS_COMPARE_A);
  assign wr_cmp[1] = do_write && (waddr_q == OFS_COMPARE_B);
  assign wr_cap = do_write && (waddr_q == OFS_CAPTURE);
  assign wr_flags = do_write && (waddr_q == OFS_FLAGS);

  // Handshake state of the write channels
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= !aw_full_d;
      wready_q <= !w_full_d;
      if (s_axi_awvalid && awready_q)
      begin
        waddr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ctrl || wr_cmp[0] || wr_cmp[1] || wr_cap || wr_flags
                    || waddr_q == OFS_COUNTER) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Bus read path
  // ****************************************
  assign ar_hs = s_axi_arvalid && arready_q;
  assign rvalid_d = ar_hs || (rvalid_q && !s_axi_rready);

  // Read data is captured on the address handshake
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_hs)
      begin
        rresp_q <= RESP_OKAY;
        case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
          OFS_CONTROL: rdata_q <= {17'h00000, ctrl_q};
          OFS_COUNTER: rdata_q <= {16'h0000, counter_value_q};
          OFS_COMPARE_A: rdata_q <= {16'h0000, compare_buf_q[0]};
          OFS_COMPARE_B: rdata_q <= {16'h0000, compare_buf_q[1]};
          OFS_CAPTURE: rdata_q <= {16'h0000, capture_register_q};
          OFS_FLAGS: rdata_q <= {23'h000000, up_q, 4'h0, flags_q};
          default:
          begin
            rdata_q <= '0;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************

  // Control register with byte enables
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= (ctrl_q & ~wmask[CTRL_W-1:0]) | wbits[CTRL_W-1:0];
    end
  end

  assign waveform_mode_field = ctrl_q[CTL_WAVE_LSB +: 4];
  assign clk_sel = ctrl_q[CTL_CLKSEL_LSB +: 3];

  // Compare writes land in the buffers only
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      compare_buf_q[0] <= CNT_RESET;
      compare_buf_q[1] <= CNT_RESET;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (wr_cmp[i])
        begin
          compare_buf_q[i] <= (compare_buf_q[i] & ~wmask[CNT_W-1:0]) | wbits[CNT_W-1:0];
        end
      end
    end
  end

  // Capture register: software value or captured count
  assign capture_event = capture_input_pin && !capture_prev_q
                         && (waveform_mode_field != WAVE_TOP_CAPTURE);
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      capture_prev_q <= 1'b0;
      capture_register_q <= CNT_RESET;
    end
    else
    begin
      capture_prev_q <= capture_input_pin;
      if (capture_event)
      begin
        capture_register_q <= counter_value_q;
      end
      else if (wr_cap)
      begin
        capture_register_q <= (capture_register_q & ~wmask[CNT_W-1:0]) | wbits[CNT_W-1:0];
      end
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  dspfc_prescaler u_prescaler (
    .clock(clock),
    .reset(reset),
    .clk_sel(clk_sel),
    .tick(timer_tick)
  );

  assign running = (waveform_mode_field == WAVE_TOP_CAPTURE)
                   || (waveform_mode_field == WAVE_TOP_COMPARE)
                   || (waveform_mode_field == WAVE_PC_COMPARE);
  assign step = timer_tick && running;
  // Toggle on output A exists only where compare A defines TOP
  assign toggle_a = (waveform_mode_field == WAVE_TOP_COMPARE)
                    || (waveform_mode_field == WAVE_PC_COMPARE);
  assign top = (waveform_mode_field == WAVE_TOP_CAPTURE) ? capture_register_q : active[0];
  assign at_bottom = (counter_value_q == CNT_BOTTOM);
  assign at_top = !at_bottom && (counter_value_q >= top);
  assign up_slope = at_bottom || (up_q && !at_top);
  // Buffers load at BOTTOM; the phase-correct variant loads at TOP
  assign load = step && ((waveform_mode_field == WAVE_PC_COMPARE) ? (at_top && up_q)
                                                                  : at_bottom);

  // Dual-slope count with a single tick at TOP
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      counter_value_q <= CNT_RESET;
      up_q <= 1'b1;
    end
    else if (step)
    begin
      if (at_bottom)
      begin
        counter_value_q <= CNT_ONE;
        up_q <= 1'b1;
      end
      else if (up_q && !at_top)
      begin
        counter_value_q <= counter_value_q + CNT_ONE;
      end
      else
      begin
        counter_value_q <= counter_value_q - CNT_ONE;
        up_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Compare channels
  // ****************************************
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_channel
    dspfc_channel u_channel (
      .clock(clock),
      .reset(reset),
      .tick(step),
      .load(load),
      .up_slope(up_slope),
      .count(counter_value_q),
      .buffer(compare_buf_q[ch]),
      .out_mode(ctrl_q[CTL_OUT_LSB + 2*ch +: 2]),
      .toggle_ok(ch == 0 && toggle_a),
      .active(active[ch]),
      .match(match[ch]),
      .level(level[ch])
    );

    // Pin shows the waveform when connected, else the port level
    always_ff @(posedge clock)
    begin
      if (reset)
      begin
        pin_out_q[ch] <= 1'b0;
        pin_oe_q[ch] <= 1'b0;
      end
      else
      begin
        case (ctrl_q[CTL_OUT_LSB + 2*ch +: 2])
          OUT_NONINV, OUT_INV: pin_out_q[ch] <= level[ch];
          OUT_TOGGLE: pin_out_q[ch] <= (ch == 0 && toggle_a)
                                       ? level[ch] : ctrl_q[CTL_PORT_LSB + ch];
          default: pin_out_q[ch] <= ctrl_q[CTL_PORT_LSB + ch];
        endcase
        pin_oe_q[ch] <= ctrl_q[CTL_DIR_LSB + ch];
      end
    end
  end

  // ****************************************
  // Flags: set wins over write-one-to-clear
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      flags_q <= '0;
    end
    else
    begin
      for (int i = 0; i < FLAG_W; i++)
      begin
        if (wr_flags && wbits[i])
        begin
          flags_q[i] <= 1'b0;
        end
      end
      if (load && at_bottom)
      begin
        flags_q[FLG_OVERFLOW] <= 1'b1;
      end
      if (step && at_bottom && waveform_mode_field == WAVE_PC_COMPARE)
      begin
        flags_q[FLG_OVERFLOW] <= 1'b1;
      end
      for (int i = 0; i < 2; i++)
      begin
        if (match[i])
        begin
          flags_q[FLG_MATCH_A + i] <= 1'b1;
        end
      end
      if (step && at_top && up_q)
      begin
        if (waveform_mode_field == WAVE_TOP_CAPTURE)
        begin
          flags_q[FLG_CAPTURE] <= 1'b1;
        end
        else
        begin
          flags_q[FLG_MATCH_A] <= 1'b1;
        end
      end
      if (capture_event)
      begin
        flags_q[FLG_CAPTURE] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_bottom_turn: assert property (@(posedge clock) disable iff (reset)
    step && at_bottom |=> counter_value_q == CNT_ONE && up_q)
    else $error("counter did not turn at bottom");
  a_top_reverse: assert property (@(posedge clock) disable iff (reset)
    step && at_top && up_q |=> counter_value_q == $past(counter_value_q) - CNT_ONE && !up_q)
    else $error("counter did not reverse after top");
  a_overflow_set: assert property (@(posedge clock) disable iff (reset)
    step && at_bottom && waveform_mode_field != WAVE_PC_COMPARE |=> flags_q[FLG_OVERFLOW])
    else $error("overflow flag missing at bottom");
  a_top_source: assert property (@(posedge clock) disable iff (reset)
    waveform_mode_field == WAVE_TOP_CAPTURE && step && up_q && !at_bottom
    |=> up_q == ($past(counter_value_q) < $past(capture_register_q)))
    else $error("top not taken from capture");
  a_tick_gates: assert property (@(posedge clock) disable iff (reset)
    !step |=> $stable(counter_value_q))
    else $error("counter moved without a tick");
  a_match_flag: assert property (@(posedge clock) disable iff (reset)
    match[1] |=> flags_q[FLG_MATCH_A + 1])
    else $error("match flag B not set");
  a_pin_enable: assert property (@(posedge clock) disable iff (reset)
    ##1 pin_oe_q[0] == $past(ctrl_q[CTL_DIR_LSB]))
    else $error("pin enable does not follow direction bit");
  a_capture_off: assert property (@(posedge clock) disable iff (reset)
    waveform_mode_field == WAVE_TOP_CAPTURE && !wr_cap |=> $stable(capture_register_q))
    else $error("capture happened while capture defines top");
  c_top_reached: cover property (@(posedge clock) disable iff (reset) step && at_top && up_q);
  c_overflow: cover property (@(posedge clock) disable iff (reset) load && at_bottom);
  c_pwm_edge: cover property (@(posedge clock) disable iff (reset) $rose(level[0]));

endmodule

// >>> sim/dspfc_load.sv
module dspfc_load
  import dspfc_pkg::*;
(
  // Pins from the timer
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  // Level seen by the load
  output logic [1:0] level
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********
  // Pin resolution
  // ********
  // Undriven pins fall to the pull-down level
  assign level = pin_out & pin_oe;
endmodule

// >>> sim/testbench.sv
module testbench
  import dspfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ********
  // Signals
  // ********
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic cap_pin = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awr, wrdy, bv, arr, rv;
  logic [1:0] br, rr, pin_out, pin_oe, lvl, wresp, rsp;
  logic [31:0] rdat, rd;
  int num_errors = 0;
  int n_tests = 0;
  int ca, cb;
  int div[5] = '{1, 8, 64, 256, 1024};

  // Clock
  always #5 clock = ~clock;

  // Timer and its load
  dspfc_timer uut
  (
    .clock(clock), .reset(reset),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .capture_input_pin(cap_pin), .wave_pin_out(pin_out), .wave_pin_oe(pin_oe)
  );
  dspfc_load load (.pin_out(pin_out), .pin_oe(pin_oe), .level(lvl));

  // ********
  // Tasks
  // ********
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bus write, each channel held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end
    while (!bv);
    wresp = br;
    bry <= 1'b0;
  endtask

  // Bus read
  task automatic rdt(input logic [7:0] a);
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arr)
        arv <= 1'b0;
    end
    while (!rv);
    rd = rdat;
    rsp = rr;
    rry <= 1'b0;
  endtask

  // Control word
  function automatic logic [31:0] ctl(input logic [3:0] wm, input logic [1:0] oa, ob,
                                      input logic [2:0] cs, input logic [1:0] dir, port);
    return {17'h00000, port, dir, cs, ob, oa, wm};
  endfunction

  // Configure, settle, then count high cycles on both pins
  task automatic run(input logic [31:0] c, input int n, input int ea, input int eb);
    wr(OFS_CONTROL, c);
    repeat (n) @(posedge clock);
    ca = 0;
    cb = 0;
    repeat (n)
    begin
      @(negedge clock);
      ca += int'(lvl[0]);
      cb += int'(lvl[1]);
    end
    chk("pin a high count", ea, ca);
    chk("pin b high count", eb, cb);
  endtask

  // Verdict
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #700000;
    num_errors++;
    final_report();
  end

  // ********
  // Scenarios
  // ********
  initial
  begin
    int n;
    logic [31:0] c;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    chk("oe after reset", 32'h0, pin_oe);
    rdt(OFS_CONTROL);
    chk("control reset", 32'h0, rd);
    wr(OFS_COUNTER, 32'h00001234);
    rdt(OFS_COUNTER);
    chk("counter read only", 32'h0, rd);
    wr(8'h18, 32'h00000001);
    chk("unmapped write resp", RESP_SLVERR, wresp);
    rdt(8'h18);
    chk("unmapped read resp", RESP_SLVERR, rsp);
    wr(OFS_COMPARE_A, 32'h0001FFFF);
    rdt(OFS_COMPARE_A);
    chk("compare a width", 32'h0000FFFF, rd);
    wr(OFS_COMPARE_A, 32'h00000003);
    wr(OFS_COMPARE_B, 32'h00000001);
    c = ctl(WAVE_TOP_COMPARE, OUT_NONINV, OUT_NONINV, CLK_DIV1, 2'h3, 2'h0);
    run(c, 12, 12, 4);
    for (int i = 0; i < 5; i++)
    begin
      n = 12 * div[i];
      c = ctl(WAVE_TOP_COMPARE, OUT_NONINV, OUT_INV, 3'(i + 1), 2'h3, 2'h0);
      run(c, n, n, n * 2 / 3);
    end
    run(ctl(WAVE_TOP_COMPARE, OUT_TOGGLE, OUT_OFF, CLK_DIV1, 2'h3, 2'h2), 12, 6, 12);
    wr(OFS_FLAGS, 32'h0000000F);
    repeat (12) @(posedge clock);
    rdt(OFS_FLAGS);
    chk("flags top from compare", 32'h7, rd & 32'hF);
    wr(OFS_COMPARE_B, 32'h00000005);
    repeat (12) @(posedge clock);
    wr(OFS_FLAGS, 32'h0000000F);
    repeat (12) @(posedge clock);
    rdt(OFS_FLAGS);
    chk("no match above top", 32'h3, rd & 32'hF);
    run(ctl(WAVE_PC_COMPARE, OUT_TOGGLE, OUT_OFF, CLK_DIV1, 2'h1, 2'h2), 12, 6, 0);
    wr(OFS_CAPTURE, 32'h00000005);
    wr(OFS_COMPARE_B, 32'h00000000);
    run(ctl(WAVE_TOP_CAPTURE, OUT_NONINV, OUT_NONINV, CLK_DIV1, 2'h3, 2'h0), 20, 12, 0);
    @(posedge clock);
    cap_pin <= 1'b1;
    rdt(OFS_CAPTURE);
    chk("capture held as top", 32'h5, rd);
    wr(OFS_FLAGS, 32'h0000000F);
    repeat (24) @(posedge clock);
    rdt(OFS_FLAGS);
    chk("flags top from capture", 32'hF, rd & 32'hF);
    wr(OFS_CONTROL, ctl(WAVE_TOP_CAPTURE, OUT_NONINV, OUT_NONINV, CLK_DIV1, 2'h0, 2'h0));
    repeat (4) @(posedge clock);
    chk("oe direction clear", 32'h0, pin_oe);
    final_report();
  end
endmodule
